// ### stp_core.sv
// Table data port and image stream readout of the scanner controller
//
// Overview of operation
// RULE_01 - Select bits 1:0 pick offset, gain or gamma table; code 3 undefined.
// RULE_02 - Select bits 3:2 pick red, green or blue; code 3 undefined.
// RULE_03 - Fourteen bit word address: high six bits reg 4, low eight reg 5.
// RULE_04 - Direction bit in reg 4: one reads with prefetch, zero writes.
// RULE_05 - Word address advances by one after each two-byte word.
// RULE_06 - Gamma address runs 0 to 4093 then wraps to zero.
// RULE_07 - Gain and offset address runs 0 to 16383 then wraps.
// RULE_08 - Register 6 moves the next sequential byte of the table.
// RULE_09 - Offset and gain words go high byte first.
// RULE_10 - Gamma first byte is four zeros then bits 11 to 8.
// RULE_11 - Host rewrites both address registers after changing the select.
// RULE_12 - Host touches the data port only while the command is zero.
// RULE_13 - Scan command first steps the count in 4A/4B, then acquires.
// RULE_14 - Scan ends on a new command or an enabled sensor change.
// RULE_15 - Line buffer clears when scanning starts; data stays readable after.
// RULE_16 - Pixel bytes come from register 0; others stay accessible.
// RULE_17 - Full buffer suspends scanning; motor power off after hold timeout.
// RULE_18 - Each line ends with a two-byte status word holding fill level.
// RULE_19 - Pixels leave in sensor order without deinterleaving.
// RULE_20 - Eight-bit line length is 2*INT(INT(P/D)*C*B/16) bytes.
// RULE_21 - Sixteen-bit mode emits two bytes per pixel, high first.
// RULE_22 - Host writes a register address once, then any number of accesses.
// RULE_23 - Host may write registers 3 to 6 while idle.
// RULE_24 - Command 1 feeds forward, 2 reverses, until zero or sensor trip.
// RULE_25 - Undefined table or color reads zero and discards writes.
// RULE_26 - Address write resets byte phase and reloads read prefetch.
`timescale 1ns/10ps

module stp_core #(
  parameter int BUF_DEPTH    = 256,
  parameter int HOLD_TIMEOUT = 10000
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                resetn,
  // Register access (address phase then data phases)
  input  wire logic                addr_wr,
  input  wire stp_pkg::stp_req_t   req,
  output logic [7:0]               rdata_r,
  // Pixel stream from the sensor path
  input  wire logic                pix_valid,
  input  wire logic [15:0]         pix_data,
  input  wire logic                pix_line_end,
  output logic                     pix_ready,
  // Mode and status
  input  wire logic                mode16,
  input  wire logic                sensor_pin,
  input  wire logic                sensor_enable,
  output logic                     motor_step_r,
  output logic                     motor_dir_r,
  output logic                     motor_power_r,
  output logic                     scanning
);

  localparam int AW = $clog2(BUF_DEPTH);

  //////////////////////////////////////////////////////////////////////////
  // Register address latch and sensor synchroniser

  logic [6:0] reg_addr_r;
  logic       sens_m_r;
  logic       sens_s_r;
  logic       sens_d_r;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      reg_addr_r <= 7'h00;
    else if (addr_wr)
      reg_addr_r <= req.addr; // [RULE_22]
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sens_m_r <= 1'b0;
      sens_s_r <= 1'b0;
      sens_d_r <= 1'b0;
    end
    else
    begin
      sens_m_r <= sensor_pin;
      sens_s_r <= sens_m_r;
      sens_d_r <= sens_s_r;
    end
  end

  wire logic wr_at  = req.wr && !addr_wr;
  wire logic rd_at  = req.rd && !addr_wr;
  wire logic sens_trip = sensor_enable && (sens_s_r != sens_d_r); // [RULE_14]

  //////////////////////////////////////////////////////////////////////////
  // Table port registers

  logic [3:0]  select_r;
  logic        dir_r;
  logic [13:0] taddr_r;
  logic        phase_r;
  logic [7:0]  first_r;
  logic [15:0] pref_r;
  logic [15:0] mem_off [0:3*16384-1];
  logic [15:0] mem_gain[0:3*16384-1];
  logic [11:0] mem_gam [0:3*4096-1];

  wire logic [1:0] tgt = select_r[stp_pkg::TARGET_LSB +: 2]; // [RULE_01]
  wire logic [1:0] col = select_r[stp_pkg::COLOR_LSB +: 2];  // [RULE_02]
  wire logic sel_ok = (tgt != stp_pkg::TGT_UNDEF) &&
                      (col != stp_pkg::COL_UNDEF); // [RULE_25]
  wire logic dp_wr = wr_at && reg_addr_r == stp_pkg::ADDR_DATA;
  wire logic dp_rd = rd_at && reg_addr_r == stp_pkg::ADDR_DATA;
  wire logic hi_wr = wr_at && reg_addr_r == stp_pkg::ADDR_ADDR_HI;
  wire logic lo_wr = wr_at && reg_addr_r == stp_pkg::ADDR_ADDR_LO;
  wire logic word_done = (dp_wr || dp_rd) && phase_r; // [RULE_05]
  wire logic [13:0] last_addr = (tgt == stp_pkg::TGT_GAMMA) ?
                      stp_pkg::GAMMA_LAST : stp_pkg::COEF_LAST;
  wire logic [13:0] taddr_inc = (taddr_r >= last_addr) ? 14'h0000 :
                      taddr_r + 14'h0001; // [RULE_06] [RULE_07]

  function automatic logic [15:0] fetch(input logic [13:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (sel_ok)
      unique case (tgt)
        stp_pkg::TGT_OFFSET: v = mem_off[{col, a}];
        stp_pkg::TGT_GAIN:   v = mem_gain[{col, a}];
        default: v = {stp_pkg::GAMMA_PAD, mem_gam[{col, a[11:0]}]}; // [RULE_10]
      endcase
    return v;
  endfunction : fetch

  wire logic [13:0] hi_addr = {req.wdata[stp_pkg::ADDR_HI_W-1:0], taddr_r[7:0]};
  wire logic [13:0] lo_addr = {taddr_r[13:8], req.wdata};

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      select_r <= 4'h0;
      dir_r    <= 1'b0;
      taddr_r  <= 14'h0000;
      phase_r  <= 1'b0;
    end
    else
    begin
      if (wr_at && reg_addr_r == stp_pkg::ADDR_SELECT)
        select_r <= req.wdata[3:0];
      if (hi_wr)
      begin
        dir_r   <= req.wdata[stp_pkg::DIR_BIT]; // [RULE_04]
        taddr_r <= hi_addr; // [RULE_03]
        phase_r <= 1'b0; // [RULE_26]
      end
      else if (lo_wr)
      begin
        taddr_r <= lo_addr; // [RULE_03]
        phase_r <= 1'b0; // [RULE_26]
      end
      else if (dp_wr || dp_rd)
      begin
        phase_r <= !phase_r; // [RULE_08]
        if (phase_r)
          taddr_r <= taddr_inc; // [RULE_05]
      end
    end
  end

  // Prefetch so reads run back to back
  always_ff @(posedge clock)
  begin
    if (hi_wr)
      pref_r <= fetch(hi_addr); // [RULE_04] [RULE_26]
    else if (lo_wr)
      pref_r <= fetch(lo_addr); // [RULE_26]
    else if (word_done)
      pref_r <= fetch(taddr_inc);
  end

  // Writes: high byte held, word stored on second byte
  always_ff @(posedge clock)
  begin
    if (dp_wr && !phase_r)
      first_r <= req.wdata; // [RULE_09]
    if (dp_wr && phase_r && !dir_r && sel_ok) // [RULE_25]
      unique case (tgt)
        stp_pkg::TGT_OFFSET: mem_off[{col, taddr_r}] <= {first_r, req.wdata};
        stp_pkg::TGT_GAIN:   mem_gain[{col, taddr_r}] <= {first_r, req.wdata};
        default: mem_gam[{col, taddr_r[11:0]}] <= {first_r[3:0], req.wdata};
      endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Command and motion sequencing

  stp_pkg::stp_mode_t mode_r;
  logic [15:0] steps_r;
  logic [15:0] step_cnt_r;
  logic [$clog2(HOLD_TIMEOUT+1)-1:0] hold_r;
  logic        buf_full;
  logic        start_scan;

  wire logic cmd_wr = wr_at && reg_addr_r == stp_pkg::ADDR_COMMAND;
  assign start_scan = cmd_wr && req.wdata == stp_pkg::CMD_SCAN;
  assign scanning   = mode_r != stp_pkg::ST_IDLE;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      steps_r <= 16'h0000;
    else if (wr_at && reg_addr_r == stp_pkg::ADDR_STEPS_H)
      steps_r[15:8] <= req.wdata;
    else if (wr_at && reg_addr_r == stp_pkg::ADDR_STEPS_L)
      steps_r[7:0] <= req.wdata;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r     <= stp_pkg::ST_IDLE;
      step_cnt_r <= 16'h0000;
      motor_dir_r <= 1'b0;
    end
    else if (cmd_wr)
    begin
      step_cnt_r <= steps_r;
      unique case (req.wdata)
        stp_pkg::CMD_SCAN: mode_r <= stp_pkg::ST_ADVANCE; // [RULE_13]
        stp_pkg::CMD_FWD:
        begin
          mode_r      <= stp_pkg::ST_FEED; // [RULE_24]
          motor_dir_r <= 1'b0;
        end
        stp_pkg::CMD_REV:
        begin
          mode_r      <= stp_pkg::ST_FEED; // [RULE_24]
          motor_dir_r <= 1'b1;
        end
        default: mode_r <= stp_pkg::ST_IDLE; // [RULE_14]
      endcase
    end
    else if (sens_trip)
      mode_r <= stp_pkg::ST_IDLE; // [RULE_14] [RULE_24]
    else if (mode_r == stp_pkg::ST_ADVANCE)
    begin
      if (step_cnt_r == 16'h0000)
        mode_r <= stp_pkg::ST_SCAN; // [RULE_13]
      else
        step_cnt_r <= step_cnt_r - 16'h0001;
    end
  end

  // Motor steps; stall when buffer full, drop power after hold time
  wire logic moving = mode_r == stp_pkg::ST_FEED ||
                      mode_r == stp_pkg::ST_ADVANCE ||
                      (mode_r == stp_pkg::ST_SCAN && !buf_full);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      motor_step_r  <= 1'b0;
      motor_power_r <= 1'b0;
      hold_r        <= '0;
    end
    else
    begin
      motor_step_r <= moving && (mode_r != stp_pkg::ST_ADVANCE ||
                                 step_cnt_r != 16'h0000);
      if (moving || !scanning)
        hold_r <= '0;
      else if (hold_r != HOLD_TIMEOUT[$bits(hold_r)-1:0])
        hold_r <= hold_r + 1'b1; // [RULE_17]
      motor_power_r <= scanning &&
                       hold_r != HOLD_TIMEOUT[$bits(hold_r)-1:0]; // [RULE_17]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Two-entry skid then line buffer

  logic [1:0][16:0] skid_r;
  logic [1:0]      skid_cnt_r;
  logic            hi_pend_r;
  logic [7:0]      lo_keep_r;
  logic            lend_keep_r;
  logic [1:0]      stat_cnt_r;
  logic [7:0]      buf_mem[0:BUF_DEPTH-1];
  logic [AW:0]     wp_r, rp_r;

  wire logic [AW:0] fill = wp_r - rp_r;
  assign buf_full  = fill[AW];
  wire logic buf_empty = fill == '0;
  wire logic [7:0] fill_lvl = fill[AW:AW-7];

  // Source side of the line buffer: one byte per clock
  logic [7:0] src_byte;
  logic       src_valid;
  always_comb
  begin
    src_byte  = mode16 ? skid_r[0][15:8] : skid_r[0][7:0];
    src_valid = skid_cnt_r != 2'h0 || hi_pend_r || stat_cnt_r != 2'h0;
    if (hi_pend_r)
      src_byte = lo_keep_r; // [RULE_21]
    else if (stat_cnt_r == 2'h2)
      src_byte = 8'h00; // [RULE_18]
    else if (stat_cnt_r == 2'h1)
      src_byte = fill_lvl; // [RULE_18]
  end
  wire logic src_take = src_valid && !buf_full && mode_r == stp_pkg::ST_SCAN;
  wire logic head_pop = src_take && !hi_pend_r && stat_cnt_r == 2'h0;
  assign pix_ready = skid_cnt_r != 2'h2;
  wire logic push = pix_valid && pix_ready;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      skid_cnt_r  <= 2'h0;
      hi_pend_r   <= 1'b0;
      lend_keep_r <= 1'b0;
      stat_cnt_r  <= 2'h0;
    end
    else
    begin
      if (push && !head_pop)
        skid_cnt_r <= skid_cnt_r + 2'h1;
      else if (head_pop && !push)
        skid_cnt_r <= skid_cnt_r - 2'h1;
      if (head_pop)
      begin
        hi_pend_r   <= mode16; // [RULE_21]
        lend_keep_r <= skid_r[0][16];
        if (skid_r[0][16] && !mode16)
          stat_cnt_r <= 2'h2; // [RULE_18]
      end
      else if (src_take && hi_pend_r)
      begin
        hi_pend_r <= 1'b0;
        if (lend_keep_r)
          stat_cnt_r <= 2'h2; // [RULE_18]
      end
      else if (src_take)
        stat_cnt_r <= stat_cnt_r - 2'h1;
    end
  end

  // Skid storage; sensor order kept as received
  always_ff @(posedge clock)
  begin
    if (head_pop)
      skid_r[0] <= (skid_cnt_r == 2'h2) ? skid_r[1] :
                   {pix_line_end, pix_data};
    if (push)
    begin
      if (skid_cnt_r == 2'h0 || (skid_cnt_r == 2'h1 && head_pop))
        skid_r[0] <= {pix_line_end, pix_data}; // [RULE_19]
      else
        skid_r[1] <= {pix_line_end, pix_data};
    end
    if (head_pop)
      lo_keep_r <= skid_r[0][7:0];
  end

  wire logic img_rd = rd_at && reg_addr_r == stp_pkg::ADDR_IMAGE; // [RULE_16]

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else if (start_scan)
    begin
      wp_r <= '0; // [RULE_15]
      rp_r <= '0;
    end
    else
    begin
      if (src_take)
        wp_r <= wp_r + 1'b1;
      if (img_rd && !buf_empty)
        rp_r <= rp_r + 1'b1; // [RULE_15]
    end
  end

  always_ff @(posedge clock)
  begin
    if (src_take)
      buf_mem[wp_r[AW-1:0]] <= src_byte; // [RULE_18]
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= 8'h00;
    else if (req.rd)
      unique case (reg_addr_r)
        stp_pkg::ADDR_IMAGE:   rdata_r <= buf_empty ? 8'h00 :
                                          buf_mem[rp_r[AW-1:0]];
        stp_pkg::ADDR_FILL:    rdata_r <= fill_lvl;
        stp_pkg::ADDR_SELECT:  rdata_r <= {4'h0, select_r};
        stp_pkg::ADDR_ADDR_HI: rdata_r <= {1'b0, dir_r, taddr_r[13:8]};
        stp_pkg::ADDR_ADDR_LO: rdata_r <= taddr_r[7:0];
        stp_pkg::ADDR_DATA:    rdata_r <= phase_r ? pref_r[7:0] :
                                          pref_r[15:8]; // [RULE_09]
        stp_pkg::ADDR_COMMAND: rdata_r <= {7'h00, scanning};
        default:               rdata_r <= 8'h00;
      endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  sequence second_byte_s;
    (dp_wr || dp_rd) && phase_r && !hi_wr && !lo_wr;
  endsequence

  addr_advance_a: assert property (@(posedge clock) disable iff (!resetn)
    second_byte_s |=> taddr_r == $past(taddr_inc)) // [RULE_05]
    else $error("Table address did not advance");
  gamma_wrap_a: assert property (@(posedge clock) disable iff (!resetn)
    second_byte_s and tgt == stp_pkg::TGT_GAMMA |=>
      taddr_r <= stp_pkg::GAMMA_LAST) // [RULE_06]
    else $error("Gamma address past last");
  phase_reset_a: assert property (@(posedge clock) disable iff (!resetn)
    (hi_wr || lo_wr) |=> !phase_r) // [RULE_26]
    else $error("Byte phase not reset");
  buf_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    start_scan |=> buf_empty) // [RULE_15]
    else $error("Buffer not cleared");
  feed_stop_a: assert property (@(posedge clock) disable iff (!resetn)
    sens_trip && !cmd_wr |=> !scanning) // [RULE_14]
    else $error("Sensor trip ignored");
  full_stall_a: assert property (@(posedge clock) disable iff (!resetn)
    buf_full && mode_r == stp_pkg::ST_SCAN |=> !motor_step_r) // [RULE_17]
    else $error("Motor stepped with full buffer");
  scan_advance_a: assert property (@(posedge clock) disable iff (!resetn)
    start_scan |=> mode_r == stp_pkg::ST_ADVANCE) // [RULE_13]
    else $error("Scan did not advance first");
  undef_zero_a: assert property (@(posedge clock) disable iff (!resetn)
    !sel_ok && (hi_wr || lo_wr) |=> pref_r == 16'h0000) // [RULE_25]
    else $error("Undefined select gave data");

endmodule : stp_core

// ### stp_core_tb_top.sv
// Self-checking bench for the table port and image readout
`timescale 1ns/10ps

module stp_core_tb_top;
  logic              clock;
  logic              resetn;
  logic              addr_wr;
  stp_pkg::stp_req_t req;
  logic [7:0]        rdata_r;
  logic              pix_valid;
  logic [15:0]       pix_data;
  logic              pix_line_end;
  logic              pix_ready;
  logic              mode16;
  logic              sensor_pin;
  logic              sensor_enable;
  logic              motor_step_r;
  logic              motor_dir_r;
  logic              motor_power_r;
  logic              scanning;
  logic [8:0]        exp_q[$];
  logic [8:0]        e;
  logic              rd_taken;
  logic [15:0]       wv[0:8][0:1];
  logic [15:0]       wz[0:1];
  logic [15:0]       pv[0:2];
  logic [13:0]       last;
  logic [1:0]        dirs;
  int                fails;
  int                num_checks;

  stp_core #(.BUF_DEPTH(256), .HOLD_TIMEOUT(20)) stp_core_i (
    .clock(clock), .resetn(resetn), .addr_wr(addr_wr), .req(req),
    .rdata_r(rdata_r), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_line_end(pix_line_end), .pix_ready(pix_ready), .mode16(mode16),
    .sensor_pin(sensor_pin), .sensor_enable(sensor_enable),
    .motor_step_r(motor_step_r), .motor_dir_r(motor_dir_r),
    .motor_power_r(motor_power_r), .scanning(scanning)
  );

  stp_host stp_host_i (.clock(clock), .addr_wr(addr_wr), .req(req));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  ////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks: %0d, mismatches: %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic logic [7:0] hi(input int t, input logic [15:0] w);
    return (t == 2) ? {stp_pkg::GAMMA_PAD, w[11:8]} : w[15:8];
  endfunction : hi

  // Note the expected byte, then issue the read
  task automatic get(input logic [7:0] v, input logic dc = 1'b0);
    exp_q.push_back({dc, v});
    stp_host_i.get_byte();
  endtask : get

  task automatic wait_scan(input logic v);
    int n;
    for (n = 0; n < 60 && scanning !== v; n++)
      @(negedge clock);
    chk(scanning === v, "scanning level");
    if (scanning !== v)
      wrap_up();
  endtask : wait_scan

  // Hold the pixel until the edge that sees ready
  task automatic push_pix(input logic [15:0] d, input logic lst);
    int n;
    pix_valid    <= 1'b1;
    pix_data     <= d;
    pix_line_end <= lst;
    for (n = 0; n < 50; n++)
    begin
      @(negedge clock);
      if (pix_ready === 1'b1)
        break;
    end
    chk(n < 50, "pixel stall");
    if (n == 50)
      wrap_up();
    @(posedge clock);
  endtask : push_pix

  ////////////////////////////////////////
  // Read result monitor
  always @(posedge clock)
    rd_taken <= req.rd & ~addr_wr;

  always @(negedge clock)
    if (rd_taken === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(1'b0, "unexpected read");
      else
      begin
        e = exp_q.pop_front();
        if (!e[8])
          chk(rdata_r === e[7:0], $sformatf("read %h exp %h", rdata_r, e));
      end
    end

  initial
  begin
    repeat (100000) @(posedge clock);
    fails++;
    $display("Error at %0t: run timed out", $time);
    wrap_up();
  end

  ////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    pix_valid = 1'b0;
    pix_data = 16'h0000;
    pix_line_end = 1'b0;
    mode16 = 1'b1;
    sensor_pin = 1'b0;
    sensor_enable = 1'b1;
    rd_taken = 1'b0;
    fails = 0;
    num_checks = 0;
    void'($urandom(32'h7f0a));
    repeat (16) @(posedge clock);
    chk(rdata_r === 8'h00 && scanning === 1'b0, "reset outputs");
    resetn <= 1'b1;
    for (int t = 0; t < 3; t++)
      for (int c = 0; c < 3; c++)
      begin
        stp_host_i.setup({4'h0, c[1:0], t[1:0]}, 14'd5, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
          wv[t*3+c][k] = 16'($urandom());
          stp_host_i.put_byte(wv[t*3+c][k][15:8]);
          stp_host_i.put_byte(wv[t*3+c][k][7:0]);
        end
      end
    for (int t = 0; t < 3; t++)
      for (int c = 0; c < 3; c++)
      begin
        stp_host_i.setup({4'h0, c[1:0], t[1:0]}, 14'd5, 1'b1);
        for (int k = 0; k < 2; k++)
        begin
          get(hi(t, wv[t*3+c][k]));
          get(wv[t*3+c][k][7:0]);
        end
      end
    for (int t = 1; t < 3; t++)
    begin
      last = (t == 2) ? stp_pkg::GAMMA_LAST : stp_pkg::COEF_LAST;
      stp_host_i.setup({6'h00, t[1:0]}, last, 1'b0);
      for (int k = 0; k < 2; k++)
      begin
        wz[k] = 16'($urandom());
        stp_host_i.put_byte(wz[k][15:8]);
        stp_host_i.put_byte(wz[k][7:0]);
      end
      stp_host_i.setup({6'h00, t[1:0]}, last, 1'b1);
      for (int k = 0; k < 2; k++)
      begin
        get(hi(t, wz[k]));
        get(wz[k][7:0]);
      end
    end
    for (int u = 0; u < 2; u++)
    begin
      stp_host_i.setup(u ? 8'h0d : 8'h03, 14'd5, 1'b0);
      stp_host_i.put_byte(8'hff);
      stp_host_i.put_byte(8'hff);
      stp_host_i.setup(u ? 8'h0d : 8'h03, 14'd5, 1'b1);
      get(8'h00);
      get(8'h00);
    end
    stp_host_i.setup(8'h01, 14'd5, 1'b1);
    get(wv[3][0][15:8]);
    stp_host_i.write_reg(stp_pkg::ADDR_ADDR_LO, 8'h05);
    stp_host_i.set_reg(stp_pkg::ADDR_DATA);
    get(wv[3][0][15:8]);
    get(wv[3][0][7:0]);
    stp_host_i.idle();
    for (int m = 1; m < 3; m++)
    begin
      stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, 8'(m));
      wait_scan(1'b1);
      @(negedge clock);
      chk(motor_power_r === 1'b1 && motor_step_r === 1'b1, "motor on");
      dirs[m-1] = motor_dir_r;
      stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, stp_pkg::CMD_IDLE);
      wait_scan(1'b0);
      @(negedge clock);
      chk(motor_power_r === 1'b0, "motor off");
    end
    chk(dirs === 2'b10, "feed direction");
    stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, stp_pkg::CMD_FWD);
    wait_scan(1'b1);
    @(posedge clock);
    sensor_pin <= ~sensor_pin;
    wait_scan(1'b0);
    stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, stp_pkg::CMD_IDLE);
    stp_host_i.write_reg(stp_pkg::ADDR_STEPS_H, 8'h00);
    stp_host_i.write_reg(stp_pkg::ADDR_STEPS_L, 8'h03);
    stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, stp_pkg::CMD_SCAN);
    wait_scan(1'b1);
    repeat (10) @(posedge clock);
    for (int k = 0; k < 3; k++)
    begin
      pv[k] = 16'($urandom());
      push_pix(pv[k], k == 2);
    end
    pix_valid <= 1'b0;
    repeat (12) @(posedge clock);
    stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, stp_pkg::CMD_IDLE);
    wait_scan(1'b0);
    stp_host_i.set_reg(stp_pkg::ADDR_IMAGE);
    for (int k = 0; k < 3; k++)
    begin
      get(pv[k][15:8]);
      get(pv[k][7:0]);
    end
    get(8'h00);
    get(8'h00, 1'b1);
    mode16 <= 1'b0;
    stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, stp_pkg::CMD_SCAN);
    wait_scan(1'b1);
    repeat (10) @(posedge clock);
    for (int k = 0; k < 2; k++)
    begin
      pv[k] = 16'($urandom());
      push_pix(pv[k], k == 1);
    end
    pix_valid <= 1'b0;
    repeat (12) @(posedge clock);
    stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, stp_pkg::CMD_IDLE);
    wait_scan(1'b0);
    stp_host_i.set_reg(stp_pkg::ADDR_IMAGE);
    get(pv[0][7:0]);
    get(pv[1][7:0]);
    get(8'h00);
    get(8'h00, 1'b1);
    stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, stp_pkg::CMD_SCAN);
    stp_host_i.write_reg(stp_pkg::ADDR_COMMAND, stp_pkg::CMD_IDLE);
    wait_scan(1'b0);
    stp_host_i.set_reg(stp_pkg::ADDR_IMAGE);
    get(8'h00);
    stp_host_i.idle();
    repeat (3) @(posedge clock);
    chk(exp_q.size() == 0, "reads left over");
    wrap_up();
  end
endmodule : stp_core_tb_top

// ### stp_host.sv
// Host model speaking the two-step register protocol
`timescale 1ns/10ps

module stp_host (
  // Clock
  input  wire logic         clock,
  // Register access
  output logic              addr_wr,
  output stp_pkg::stp_req_t req
);
  initial
  begin
    addr_wr = 1'b0;
    req     = '0;
  end

  ////////////////////////////////////////
  // Address phase; later data phases reuse it
  task automatic set_reg(input logic [6:0] a);
    @(posedge clock);
    addr_wr <= 1'b1;
    req     <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~req.wdata};
  endtask : set_reg

  task automatic put_byte(input logic [7:0] d);
    @(posedge clock);
    addr_wr <= 1'b0;
    req     <= '{wr: 1'b1, rd: 1'b0, addr: ~req.addr, wdata: d};
  endtask : put_byte

  task automatic get_byte();
    @(posedge clock);
    addr_wr <= 1'b0;
    req     <= '{wr: 1'b0, rd: 1'b1, addr: ~req.addr, wdata: ~req.wdata};
  endtask : get_byte

  task automatic idle();
    @(posedge clock);
    addr_wr <= 1'b0;
    req     <= '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
  endtask : idle

  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    set_reg(a);
    put_byte(d);
    idle();
  endtask : write_reg

  ////////////////////////////////////////
  // Select, both address bytes, then point at the data port; idle only
  task automatic setup(input logic [7:0] sel, input logic [13:0] a,
                       input logic dir);
    write_reg(stp_pkg::ADDR_SELECT, sel);
    write_reg(stp_pkg::ADDR_ADDR_HI, {1'b0, dir, a[13:8]});
    write_reg(stp_pkg::ADDR_ADDR_LO, a[7:0]);
    set_reg(stp_pkg::ADDR_DATA);
  endtask : setup
endmodule : stp_host

// ### stp_pkg.sv
// Shared constants and types for the scanner table port and image readout
package stp_pkg;

  // Register addresses
  localparam logic [6:0] ADDR_IMAGE   = 7'h00;
  localparam logic [6:0] ADDR_FILL    = 7'h01;
  localparam logic [6:0] ADDR_SELECT  = 7'h03;
  localparam logic [6:0] ADDR_ADDR_HI = 7'h04;
  localparam logic [6:0] ADDR_ADDR_LO = 7'h05;
  localparam logic [6:0] ADDR_DATA    = 7'h06;
  localparam logic [6:0] ADDR_COMMAND = 7'h07;
  localparam logic [6:0] ADDR_STEPS_H = 7'h4a;
  localparam logic [6:0] ADDR_STEPS_L = 7'h4b;

  // Field positions
  localparam int TARGET_LSB  = 0;
  localparam int COLOR_LSB   = 2;
  localparam int DIR_BIT     = 6;
  localparam int ADDR_HI_W   = 6;

  // Table targets and colors
  localparam logic [1:0] TGT_OFFSET = 2'h0;
  localparam logic [1:0] TGT_GAIN   = 2'h1;
  localparam logic [1:0] TGT_GAMMA  = 2'h2;
  localparam logic [1:0] TGT_UNDEF  = 2'h3;
  localparam logic [1:0] COL_UNDEF  = 2'h3;

  // Address limits
  localparam logic [13:0] GAMMA_LAST = 14'h0ffd;
  localparam logic [13:0] COEF_LAST  = 14'h3fff;
  localparam logic [3:0]  GAMMA_PAD  = 4'h0;

  // Command codes
  localparam logic [7:0] CMD_IDLE    = 8'h00;
  localparam logic [7:0] CMD_FWD     = 8'h01;
  localparam logic [7:0] CMD_REV     = 8'h02;
  localparam logic [7:0] CMD_SCAN    = 8'h08;

  // Bus request strobe and scan mode states
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } stp_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ADVANCE, ST_SCAN, ST_FEED} stp_mode_t;

endpackage : stp_pkg
